// ==== rtl/spc_pkg.sv ====
// Package with register map, field positions, reset values and timing for the SPI pin control.
package spc_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CONTROL_ONE  = 8'h00;
    localparam logic [7:0] IDX_CONTROL_TWO  = 8'h01;
    localparam logic [7:0] IDX_DATA         = 8'h02;
    localparam logic [7:0] IDX_STATUS       = 8'h03;
    localparam logic [7:0] IDX_MATCH        = 8'h04;
    localparam logic [7:0] IDX_WAIT         = 8'h05;
    // ------------------------------------------------------------------
    // Control two fields
    // ------------------------------------------------------------------
    localparam int C2_MATCH_IRQ_ENABLE = 7;
    localparam int C2_MODE_FAULT_ENABLE = 4;
    localparam int C2_SINGLE_WIRE_OE   = 3;
    localparam int C2_STOP_IN_WAIT     = 1;
    localparam int C2_PIN_MODE         = 0;
    localparam logic [7:0] C2_WRITABLE = 8'h9b;
    localparam logic [7:0] C2_RESET    = 8'h00;
    // ------------------------------------------------------------------
    // Control one fields
    // ------------------------------------------------------------------
    localparam int C1_IRQ_ENABLE       = 7;
    localparam int C1_MASTER_SELECT    = 4;
    localparam int C1_SELECT_OUT_EN    = 1;
    localparam logic [7:0] C1_WRITABLE = 8'h92;
    localparam logic [7:0] C1_RESET    = 8'h00;
    // ------------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------------
    localparam int ST_RX_FULL          = 7;
    localparam int ST_MATCH            = 6;
    localparam int ST_MODE_FAULT       = 4;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ              = 10_000_000;
    localparam int SCK_HALF_NS         = 500;
    localparam int SCK_HALF_CYCLES     = (SCK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
endpackage

// ==== rtl/spc_shift_core.sv ====
// Link-clock shift register for one byte, transmit and receive, slave and master.
`timescale 1ns/1ns
module spc_shift_core #(
    parameter int WIDTH = 8
) (
    input  wire logic             link_clk,
    input  wire logic             resetn,
    input  wire logic             frame_active,
    input  wire logic             serial_in,
    input  wire logic [WIDTH-1:0] load_data,
    output logic                  serial_out,
    output logic [WIDTH-1:0]      rx_word,
    output logic                  rx_toggle
);
    initial begin
        if (WIDTH < 2) begin
            $error("spc_shift_core needs WIDTH of at least 2");
        end
    end

    logic [WIDTH-1:0]          shift;
    logic [$clog2(WIDTH)-1:0]  count;
    wire  logic                last_bit = (count == WIDTH[$clog2(WIDTH)-1:0] - 1'b1);

    assign serial_out = shift[WIDTH-1];

    // The shifter loads load_data and its count clears while no frame is active, since the link clock may stop between frames.
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            shift     <= '0;
            count     <= '0;
            rx_word   <= '0;
            rx_toggle <= 1'b0;
        end else if (!frame_active) begin
            shift <= load_data;
            count <= '0;
        end else begin
            shift <= {shift[WIDTH-2:0], serial_in};
            count <= last_bit ? '0 : count + 1'b1;
            if (last_bit) begin
                rx_word   <= {shift[WIDTH-2:0], serial_in};
                rx_toggle <= ~rx_toggle;
            end
        end
    end
endmodule

// ==== rtl/spc_pin_control.sv ====
// SPI pin and fault control with APB registers and a link-clock shifter.
//
// Behaviour
// [RULE_01] Control two is eight bits, read/write, reset zero; bit 6 reads zero.
// [RULE_02] Match enable and match flag together raise the interrupt request.
// [RULE_03] In slave mode the fault enable is ignored; select pin is slave select.
// [RULE_04] Master with fault enable clear releases select pin to general I/O.
// [RULE_05] Master with fault enable set: select pin is fault input or select output.
// [RULE_06] In single-wire mode the output enable gates the driver onto the shared pin.
// [RULE_07] In two-wire mode the single-wire output enable affects no pin.
// [RULE_08] Single-wire enable zero makes the shared pin input; one makes it output.
// [RULE_09] Stop-in-wait set freezes the unit while the processor waits.
// [RULE_10] Two-wire mode uses separate pins according to master or slave role.
// [RULE_11] Single-wire master uses master-out pin only, slave-out unused.
// [RULE_12] Single-wire slave uses slave-out pin only, master-out unused.
// [RULE_13] Software must not write reserved bits 6, 5 and 2.
// [RULE_14] Select output enable zero means fault input; one means automatic select output.
// [RULE_15] Master select one makes the unit master; zero makes it slave.
// [RULE_16] Automatic select output is low during a transfer and high between.
// [RULE_17] Low select input in fault mode sets the mode fault flag, feeding the interrupt.
`timescale 1ns/1ns
module spc_pin_control #(
    parameter int WIDTH = 8
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        cpu_wait,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        link_clk,
    input  wire logic        select_in,
    output logic             select_out,
    output logic             select_oe,
    input  wire logic        master_shared_data_pin_in,
    output logic             master_shared_data_pin_out,
    output logic             master_shared_data_pin_oe,
    input  wire logic        slave_shared_data_pin_in,
    output logic             slave_shared_data_pin_out,
    output logic             slave_shared_data_pin_oe,
    output logic             select_gpio_released
);
    initial begin
        if (WIDTH != 8) begin
            $error("spc_pin_control supports only WIDTH of 8");
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] spi_control_one;
    logic [7:0] spi_control_two;
    logic [7:0] match_value;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic       rx_full;
    logic       receive_match_flag;
    logic       mode_fault_flag;
    logic       transfer_busy;

    wire logic match_irq_enable   = spi_control_two[spc_pkg::C2_MATCH_IRQ_ENABLE];
    wire logic mode_fault_enable  = spi_control_two[spc_pkg::C2_MODE_FAULT_ENABLE];
    wire logic single_wire_output_enable = spi_control_two[spc_pkg::C2_SINGLE_WIRE_OE];
    wire logic stop_in_wait       = spi_control_two[spc_pkg::C2_STOP_IN_WAIT];
    wire logic single_wire_pin_mode = spi_control_two[spc_pkg::C2_PIN_MODE];
    wire logic master_select      = spi_control_one[spc_pkg::C1_MASTER_SELECT]; // RULE_15
    wire logic select_output_enable = spi_control_one[spc_pkg::C1_SELECT_OUT_EN];
    wire logic rx_irq_enable      = spi_control_one[spc_pkg::C1_IRQ_ENABLE];

    // Freezing with stop-in-wait gates register writes, transfer control and flags; the select and done synchronisers keep running, the bus still answers.
    wire logic run = clk_en && !(stop_in_wait && cpu_wait); // RULE_09

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire logic [7:0] word_index = paddr[9:2];
    wire logic       in_range   = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0);
    wire logic       hit_c1     = in_range && (word_index == spc_pkg::IDX_CONTROL_ONE);
    wire logic       hit_c2     = in_range && (word_index == spc_pkg::IDX_CONTROL_TWO);
    wire logic       hit_data   = in_range && (word_index == spc_pkg::IDX_DATA);
    wire logic       hit_status = in_range && (word_index == spc_pkg::IDX_STATUS);
    wire logic       hit_match  = in_range && (word_index == spc_pkg::IDX_MATCH);
    wire logic       hit_wait   = in_range && (word_index == spc_pkg::IDX_WAIT);
    wire logic       mapped     = hit_c1 | hit_c2 | hit_data | hit_status | hit_match | hit_wait;
    wire logic       access     = psel && penable && clk_en;
    wire logic       wr_stb     = access && pwrite && run;
    wire logic       rd_data_stb = access && !pwrite && hit_data && run;

    assign pready  = clk_en;
    assign pslverr = psel && penable && !mapped;

    wire logic [7:0] status_value = {rx_full, receive_match_flag, 1'b0, mode_fault_flag,
                                     3'h0, transfer_busy};
    // Writes to reserved bits are masked off so they stay zero even if software misbehaves.
    wire logic [7:0] c2_write = pwdata[7:0] & spc_pkg::C2_WRITABLE; // RULE_01 RULE_13
    wire logic [7:0] read_mux =
        hit_c1     ? spi_control_one :
        hit_c2     ? spi_control_two :
        hit_data   ? rx_data :
        hit_status ? status_value :
        hit_match  ? match_value :
        hit_wait   ? {7'h00, cpu_wait} : 8'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && clk_en) begin
            prdata <= {24'h000000, read_mux};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spi_control_one <= spc_pkg::C1_RESET;
            spi_control_two <= spc_pkg::C2_RESET; // RULE_01
            match_value     <= 8'h00;
            tx_data         <= 8'h00;
        end else if (wr_stb) begin
            if (hit_c1) spi_control_one <= pwdata[7:0] & spc_pkg::C1_WRITABLE;
            if (hit_c2) spi_control_two <= c2_write;
            if (hit_match) match_value <= pwdata[7:0];
            if (hit_data) tx_data <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Select pin function
    // ------------------------------------------------------------------
    logic [1:0] sel_sync;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_sync <= 2'h3;
        end else if (clk_en) begin
            sel_sync <= {sel_sync[0], select_in};
        end
    end
    wire logic select_level = sel_sync[1];

    wire logic fault_function = master_select && mode_fault_enable; // RULE_03 RULE_05
    wire logic auto_select    = fault_function && select_output_enable; // RULE_14
    wire logic fault_input    = fault_function && !select_output_enable; // RULE_14
    assign select_gpio_released = master_select && !mode_fault_enable; // RULE_04
    assign select_oe  = auto_select;
    assign select_out = !transfer_busy; // RULE_16
    wire logic slave_selected = !master_select && !select_level; // RULE_03

    // ------------------------------------------------------------------
    // Transfer control and link crossing
    // ------------------------------------------------------------------
    logic       start_req;
    logic [1:0] done_sync;
    logic       done_seen;
    logic       rx_toggle;
    logic [7:0] rx_word;

    wire logic start_write = wr_stb && hit_data && master_select;
    wire logic done_event  = done_sync[1] ^ done_seen;
    wire logic frame_active = master_select ? transfer_busy : slave_selected;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_sync <= 2'h0;
            done_seen <= 1'b0;
        end else if (clk_en) begin
            done_sync <= {done_sync[0], rx_toggle};
            done_seen <= done_sync[1];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transfer_busy <= 1'b0;
        end else if (run) begin
            if (start_write) transfer_busy <= 1'b1;
            else if (done_event || (fault_input && !select_level)) transfer_busy <= 1'b0;
        end
    end

    wire logic match_hit = done_event && (rx_word == match_value);
    wire logic clear_status = rd_data_stb;

    // Flag sets win over the clear by a data read in the same cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_data            <= 8'h00;
            rx_full            <= 1'b0;
            receive_match_flag <= 1'b0;
            mode_fault_flag    <= 1'b0;
        end else if (run) begin
            if (done_event) rx_data <= rx_word;
            rx_full <= done_event | (rx_full & ~clear_status);
            receive_match_flag <= match_hit | (receive_match_flag & ~clear_status);
            mode_fault_flag <= (fault_input && !select_level) | // RULE_17
                               (mode_fault_flag & ~(wr_stb && hit_c1));
        end
    end

    assign irq = (match_irq_enable && receive_match_flag) || // RULE_02
                 (rx_irq_enable && (rx_full || mode_fault_flag)); // RULE_17

    // The master's frame level crosses into the link domain through two flip-flops.
    logic [1:0] frame_sync;
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            frame_sync <= 2'h0;
        end else begin
            frame_sync <= {frame_sync[0], frame_active};
        end
    end

    // ------------------------------------------------------------------
    // Data pins
    // ------------------------------------------------------------------
    wire logic serial_out;
    // A slave's link clock stands still outside frames, so the select pin cannot pass a
    // synchroniser in that domain; it already belongs to the link domain and gates the shifter.
    wire logic shift_frame  = master_select ? frame_sync[1] : !select_in; // RULE_03
    wire logic drive_shared = single_wire_output_enable; // RULE_06 RULE_08
    wire logic serial_in =
        !single_wire_pin_mode ? (master_select ? slave_shared_data_pin_in       // RULE_10
                                               : master_shared_data_pin_in) :
        (master_select ? master_shared_data_pin_in : slave_shared_data_pin_in); // RULE_11 RULE_12

    assign master_shared_data_pin_out = serial_out;
    assign slave_shared_data_pin_out  = serial_out;
    // Two-wire mode ignores the single-wire enable entirely.
    assign master_shared_data_pin_oe = master_select &&
        (!single_wire_pin_mode || drive_shared); // RULE_07 RULE_10 RULE_11
    assign slave_shared_data_pin_oe  = !master_select && slave_selected &&
        (!single_wire_pin_mode || drive_shared); // RULE_07 RULE_10 RULE_12

    spc_shift_core #(
        .WIDTH (WIDTH)
    ) u_shift (
        .link_clk     (link_clk),
        .resetn       (resetn),
        .frame_active (shift_frame),
        .serial_in    (serial_in),
        .load_data    (tx_data),
        .serial_out   (serial_out),
        .rx_word      (rx_word),
        .rx_toggle    (rx_toggle)
    );
endmodule

// ==== verification/spc_pin_control_asserts.sv ====
// Checker for the SPI pin control ports, holding a shadow of both control registers.
`timescale 1ns/1ns
module spc_pin_control_asserts (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        clk_en,
    input wire logic        cpu_wait,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        select_out,
    input wire logic        select_oe,
    input wire logic        select_gpio_released,
    input wire logic        master_shared_data_pin_oe,
    input wire logic        slave_shared_data_pin_oe
);
    // ------------------------------------------------------------------
    // Register shadow and properties
    // ------------------------------------------------------------------
    // Writes made while frozen are dropped here too, so the shadow never runs ahead of the unit.
    logic [7:0] c1;
    logic [7:0] c2;
    logic       wr_ok;
    assign wr_ok = psel && penable && pwrite && clk_en && !(c2[1] && cpu_wait);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            c1 <= 8'h00;
            c2 <= 8'h00;
        end else if (wr_ok) begin
            c1 <= (paddr == 32'h0) ? (pwdata[7:0] & spc_pkg::C1_WRITABLE) : c1;
            c2 <= (paddr == 32'h4) ? (pwdata[7:0] & spc_pkg::C2_WRITABLE) : c2;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_C2_READ: assert property (psel && penable && !pwrite && paddr == 32'h4 |-> prdata == {24'h0, c2})
        else $error("control two read value wrong");
    AST_SLVERR: assert property (pslverr |-> psel && penable && (pwrite || prdata == 32'h0))
        else $error("error response wrong");
    AST_SEL_OE: assert property (select_oe == (c1[4] && c2[4] && c1[1]))
        else $error("select output enable wrong");
    AST_GPIO: assert property (select_gpio_released == (c1[4] && !c2[4]))
        else $error("select pin release wrong");
    AST_MO_QUIET: assert property (!(c1[4] && (!c2[0] || c2[3])) |-> !master_shared_data_pin_oe)
        else $error("master-out pin driven");
    AST_SO_QUIET: assert property (!(!c1[4] && (!c2[0] || c2[3])) |-> !slave_shared_data_pin_oe)
        else $error("slave-out pin driven");
    AST_IRQ_QUIET: assert property (!c1[7] && !c2[7] |-> !irq)
        else $error("interrupt while disabled");
    AST_SEL_IDLE: assert property ($rose(select_oe) |-> select_out)
        else $error("select output low when idle");
    AST_FREEZE: assert property (c2[1] && cpu_wait && $past(c2[1]) && $past(cpu_wait) |-> $stable(select_out) && $stable(irq))
        else $error("unit moved while frozen");
endmodule
bind spc_pin_control spc_pin_control_asserts u_chk (.clk, .resetn, .clk_en, .cpu_wait, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .irq, .select_out, .select_oe,
    .select_gpio_released, .master_shared_data_pin_oe, .slave_shared_data_pin_oe);

// ==== verification/spc_link_peer.sv ====
// Behavioural far-side master that clocks one byte into the unit over the link.
`timescale 1ns/1ns
module spc_link_peer (
    output logic link_clk,
    output logic data_bit
);
    // ------------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------------
    // The link clock stands still between frames, and the released data line shows the
    // inverse of its last bit so a stale level can never pass for good data.
    initial link_clk = 1'b0;
    initial data_bit = 1'b0;
    task automatic send(input logic [7:0] b);
        #37;
        for (int i = 7; i >= 0; i--) begin
            data_bit = b[i];
            #80 link_clk = 1'b1;
            #80 link_clk = 1'b0;
        end
        data_bit = ~b[0];
    endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the SPI pin control block.
`timescale 1ns/1ns
module testbench;
    logic        clk = 1'b0, resetn = 1'b0, cpu_wait = 1'b0, sel_drv = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, rdat;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, link_clk, peer_bit, sel_out, sel_oe, gpio_rel;
    wire         mo_out, mo_oe, so_out, so_oe;
    wire         sel_in = sel_oe ? sel_out : sel_drv;
    wire         mo_in = mo_oe ? mo_out : peer_bit;
    wire         so_in = so_oe ? so_out : peer_bit;
    int          num_errors = 0;
    int          n_compared = 0;
    always #50 clk = ~clk;
    spc_pin_control u_dut (.clk(clk), .resetn(resetn), .clk_en(1'b1), .cpu_wait(cpu_wait),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link_clk(link_clk),
        .select_in(sel_in), .select_out(sel_out), .select_oe(sel_oe),
        .master_shared_data_pin_in(mo_in), .master_shared_data_pin_out(mo_out),
        .master_shared_data_pin_oe(mo_oe), .slave_shared_data_pin_in(so_in),
        .slave_shared_data_pin_out(so_out), .slave_shared_data_pin_oe(so_oe),
        .select_gpio_released(gpio_rel));
    spc_link_peer u_peer (.link_clk(link_clk), .data_bit(peer_bit));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // The idle edge at the end keeps two transfers from driving psel twice in one step.
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) begin
            num_errors++;
            report_and_stop();
        end
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rd(32'h4, 32'h0);
        apb(1'b1, 32'h4, 32'h9b);
        rd(32'h4, 32'h9b);
        apb(1'b0, 32'h40, 32'h0);
        chk(32'(rerr), 32'h1);
        cpu_wait <= 1'b1;
        apb(1'b1, 32'h4, 32'h80);
        cpu_wait <= 1'b0;
        rd(32'h4, 32'h9b);
    endtask
    task automatic t_modes();
        logic m, f, s, p, b;
        for (int i = 0; i < 32; i++) begin
            {m, f, s, p, b} = i[4:0];
            apb(1'b1, 32'h0, 32'({m, 2'h0, s, 1'h0}));
            apb(1'b1, 32'h4, 32'({f, b, 2'h0, p}));
            chk(32'({sel_oe, gpio_rel}), 32'({m & f & s, m & ~f}));
            chk(32'({mo_oe & ~(m & (~p | b)), so_oe & (m | p & ~b)}), 32'h0);
        end
    endtask
    task automatic t_fault();
        apb(1'b1, 32'h0, 32'h90);
        apb(1'b1, 32'h4, 32'h10);
        sel_drv <= 1'b0;
        repeat (4) @(posedge clk);
        sel_drv <= 1'b1;
        chk(32'(irq), 32'h1);
        rd(32'hc, 32'h10);
        apb(1'b1, 32'h0, 32'h80);
        chk(32'(irq), 32'h0);
    endtask
    task automatic t_match();
        apb(1'b1, 32'h0, 32'h00);
        apb(1'b1, 32'h10, 32'ha5);
        apb(1'b1, 32'h4, 32'h80);
        sel_drv <= 1'b0;
        @(posedge clk);
        u_peer.send(8'ha5);
        repeat (6) @(posedge clk);
        sel_drv <= 1'b1;
        chk(32'(irq), 32'h1);
        apb(1'b1, 32'h4, 32'h00);
        chk(32'(irq), 32'h0);
        rd(32'h8, 32'ha5);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_modes();
        t_fault();
        t_match();
        report_and_stop();
    end
endmodule
